// [acr_control.sv]
// register file, launch arbitration and event routing of the converter control block
//
// Contract
// - merge selector combines channel DMA requests
// - start bits launch single channel conversions
// - several starts go lowest channel first
// - start bit clears when conversion begins
// - purge discards pipeline, restarts converter clock
// - pending work resumes after purge
// - enable bit turns converter on
// - impedance bit: 0 high, 1 low
// - high impedance only at gains 1x-8x
// - current cap field limits sample rate
// - bit 4 selects signed results
// - bit 3 scans channel set continuously
// - result format field encoding
// - three-bit reference select encoding
// - bandgap bit powers bandgap
// - temperature sensor enable bit
// - scan set picks channels 0..n
// - event select picks lines from n
// - event action limits used event lines
// - event action code meanings
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_control
   import acr_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int EV_LINES = 8,
   parameter int CLK_DIV = `ACR_CLK_DIV
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] O_RDATA,
   // event lines and channel status from the converter
   input wire logic [EV_LINES-1:0] i_event,
   input wire logic [CHANNELS-1:0] i_dma_req,
   input wire logic [CHANNELS-1:0] i_gain_low,
   input wire logic i_pipe_ready,
   // converter controls
   output logic O_CONV_CLK,
   output logic O_CONV_TICK,
   output logic O_PURGE,
   output logic O_ENABLE,
   output logic [CHANNELS-1:0] O_LAUNCH,
   output logic [CHANNELS-1:0] O_DMA_REQ,
   output logic [CHANNELS-1:0] O_LOW_IMP,
   output logic [1:0] O_CURRENT_CAP,
   output logic O_SIGNED,
   output logic [1:0] O_FORMAT,
   output logic [2:0] O_REF_SELECT,
   output logic O_BANDGAP,
   output logic O_TEMP_SENSOR
);
   //-------------------------------------------------
   // registers
   //-------------------------------------------------
   logic [7:0] main_r;
   logic [7:0] mode_r;
   logic [7:0] ref_r;
   logic [7:0] trig_r;
   logic [CHANNELS-1:0] pend_r;
   logic [CHANNELS-1:0] pend_nxt;
   logic [CHANNELS-1:0] scan_r;
   logic [EV_LINES-1:0] ev_meta_r;
   logic [EV_LINES-1:0] ev_sync_r;
   logic [EV_LINES-1:0] ev_prev_r;
   logic purge_r;
   logic busy_r;
   logic conv_clk;
   logic conv_tick;
   logic enable;
   logic [1:0] merge;
   logic [1:0] sweep;
   logic [2:0] ev_sel;
   logic [2:0] ev_act;
   logic [EV_LINES-1:0] ev_rise;
   logic [CHANNELS-1:0] ev_trig;
   logic [CHANNELS-1:0] sweep_set;
   logic [CHANNELS-1:0] grant;
   logic scan_trig;
   logic sync_purge;
   logic wr_main;

   assign enable = main_r[`ACR_MAIN_ENABLE];
   assign merge = main_r[`ACR_MAIN_MERGE_LO +: 2];
   assign sweep = trig_r[`ACR_TRIG_SWEEP_LO +: 2];
   assign ev_sel = trig_r[`ACR_TRIG_SEL_LO +: 3];
   assign ev_act = trig_r[`ACR_TRIG_ACT_LO +: 3];
   assign wr_main = i_wr && (i_addr == `ACR_OFF_MAIN);

   // channels 0..n as a mask; used by both the scan set and the dma merge
   function automatic logic [CHANNELS-1:0] low_mask(input logic [1:0] n);
      logic [CHANNELS-1:0] m;
      m = '0;
      for (int k = 0; k < CHANNELS; k++) begin
         if (k <= int'(n)) begin
            m[k] = 1'b1;
         end
      end
      return m;
   endfunction

   // lowest set bit only
   function automatic logic [CHANNELS-1:0] lowest(input logic [CHANNELS-1:0] v);
      return v & (~v + CHANNELS'(1));
   endfunction

   //-------------------------------------------------
   // converter clock
   //-------------------------------------------------
   // the converter clock stops with the enable bit, so a disabled block does not switch
   acr_clock_gen #(
      .DIV(CLK_DIV)
   ) u_clk (
      .clk(I_MCLK),
      .rst(I_SYS_RST),
      .i_restart(purge_r),
      .i_run(enable),
      .o_conv_clk(conv_clk),
      .o_tick(conv_tick)
   );

   //-------------------------------------------------
   // event line synchroniser and routing
   //-------------------------------------------------
   // two flops settle the asynchronous lines; the third only finds the rising edge
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ev_meta_r <= '0;
         ev_sync_r <= '0;
         ev_prev_r <= '0;
      end else begin
         ev_meta_r <= i_event;
         ev_sync_r <= ev_meta_r;
         ev_prev_r <= ev_sync_r;
      end
   end
   assign ev_rise = ev_sync_r & ~ev_prev_r;

   // line n+k triggers channel k; lines past 7 do not exist
   generate
      for (genvar k = 0; k < CHANNELS; k++) begin : g_route
         logic [3:0] line;
         assign line = 4'(ev_sel) + 4'(k);
         assign ev_trig[k] = (line < 4'(EV_LINES)) && ev_rise[line[2:0]]
            && (ev_act >= 3'(k + 1)) && (ev_act <= ACR_ACT_CH0123);
      end
   endgenerate

   // an event that arrives while disabled is lost, not queued
   assign scan_trig = ev_rise[ev_sel] && (ev_act == ACR_ACT_SCAN || ev_act == ACR_ACT_SYNC_SCAN);
   assign sync_purge = enable && ev_rise[ev_sel] && (ev_act == ACR_ACT_SYNC_SCAN);
   assign sweep_set = low_mask(sweep);

   //-------------------------------------------------
   // launch arbitration
   //-------------------------------------------------
   // one channel enters the pipeline per converter clock, lowest first
   assign grant = (enable && conv_tick && i_pipe_ready) ? lowest(pend_r) : '0;

   // starts written together with the enable bit are gated by the old enable value
   always_comb begin
      pend_nxt = pend_r & ~grant;
      if (enable) begin
         if (wr_main) begin
            pend_nxt = pend_nxt | i_wdata[`ACR_MAIN_LAUNCH_LO +: CHANNELS];
         end
         pend_nxt = pend_nxt | ev_trig;
         if (scan_trig) begin
            pend_nxt = pend_nxt | sweep_set;
         end
         // refill when the scan has drained
         if (mode_r[`ACR_MODE_CONT] && (pend_nxt == '0)) begin
            pend_nxt = sweep_set;
         end
      end else begin
         pend_nxt = '0;
      end
   end

   // pending work survives a purge so it re-enters the pipeline afterwards
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pend_r <= '0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // purge is a single pulse; the register bit reads back as the pulse
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         purge_r <= 1'b0;
      end else begin
         purge_r <= (wr_main && i_wdata[`ACR_MAIN_PURGE]) || sync_purge;
      end
   end

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         scan_r <= '0;
         busy_r <= 1'b0;
      end else begin
         scan_r <= grant;
         // status trails the pending bits by a cycle; it is meant for polling only
         busy_r <= (pend_r != '0);
      end
   end

   //-------------------------------------------------
   // register writes
   //-------------------------------------------------
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         main_r <= `ACR_RST_MAIN;
      end else if (wr_main) begin
         // launch and purge bits are not stored; they act on the write itself
         main_r <= {i_wdata[7:6], 4'h0, 1'b0, i_wdata[0]};
      end
   end

   // reserved bits are held at zero whatever software writes
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         mode_r <= `ACR_RST_MODE;
         ref_r <= `ACR_RST_REF;
         trig_r <= `ACR_RST_TRIG;
      end else if (i_wr) begin
         case (i_addr)
            `ACR_OFF_MODE: begin
               mode_r <= i_wdata & `ACR_MODE_MASK;
            end
            `ACR_OFF_REF: begin
               ref_r <= i_wdata & `ACR_REF_MASK;
            end
            `ACR_OFF_TRIG: begin
               trig_r <= i_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   //-------------------------------------------------
   // register reads
   //-------------------------------------------------
   // reads have no side effects, so software may poll the status freely
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_RDATA <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `ACR_OFF_MAIN: begin
               O_RDATA <= {main_r[7:6], pend_r, purge_r, main_r[0]};
            end
            `ACR_OFF_MODE: begin
               O_RDATA <= mode_r;
            end
            `ACR_OFF_REF: begin
               O_RDATA <= ref_r;
            end
            `ACR_OFF_TRIG: begin
               O_RDATA <= trig_r;
            end
            `ACR_OFF_STATUS: begin
               O_RDATA <= {3'h0, busy_r, scan_r};
            end
            default: begin
               O_RDATA <= 8'h00;
            end
         endcase
      end else begin
         O_RDATA <= 8'h00;
      end
   end

   //-------------------------------------------------
   // converter controls
   //-------------------------------------------------
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_CONV_CLK <= 1'b0;
         O_CONV_TICK <= 1'b0;
         O_PURGE <= 1'b0;
         O_ENABLE <= 1'b0;
         O_LAUNCH <= '0;
      end else begin
         O_CONV_CLK <= conv_clk;
         O_CONV_TICK <= conv_tick;
         O_PURGE <= purge_r;
         O_ENABLE <= enable;
         O_LAUNCH <= grant;
      end
   end

   // merged channels share channel 0's request line and their own lines stay quiet; unmerged channels pass through
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_DMA_REQ <= '0;
      end else if (merge == 2'h0) begin
         O_DMA_REQ <= i_dma_req;
      end else begin
         O_DMA_REQ <= (i_dma_req & ~low_mask(merge))
            | CHANNELS'(|(i_dma_req & low_mask(merge)));
      end
   end

   //-------------------------------------------------
   // mode and reference fields
   //-------------------------------------------------
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_LOW_IMP <= '0;
         O_CURRENT_CAP <= 2'h0;
         O_SIGNED <= 1'b0;
         O_FORMAT <= 2'h0;
         O_REF_SELECT <= 3'h0;
         O_BANDGAP <= 1'b0;
         O_TEMP_SENSOR <= 1'b0;
      end else begin
         // high gains cannot hold charge, so they are always flushed
         O_LOW_IMP <= {CHANNELS{mode_r[`ACR_MODE_IMP]}} | i_gain_low;
         O_CURRENT_CAP <= mode_r[`ACR_MODE_CAP_LO +: 2];
         O_SIGNED <= mode_r[`ACR_MODE_SIGNED];
         O_FORMAT <= mode_r[`ACR_MODE_FMT_LO +: 2];
         O_REF_SELECT <= ref_r[`ACR_REF_SEL_LO +: 3];
         O_BANDGAP <= ref_r[`ACR_REF_BGAP];
         O_TEMP_SENSOR <= ref_r[`ACR_REF_TEMP];
      end
   end
endmodule

// [acr_defines.svh]
// register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_OFF_MAIN 8'h00
`define ACR_OFF_MODE 8'h01
`define ACR_OFF_REF 8'h02
`define ACR_OFF_TRIG 8'h03
`define ACR_OFF_STATUS 8'h04
`define ACR_RST_MAIN 8'h00
`define ACR_RST_MODE 8'h00
`define ACR_RST_REF 8'h00
`define ACR_RST_TRIG 8'h00
`define ACR_MODE_MASK 8'hfe
`define ACR_REF_MASK 8'h73
`define ACR_MAIN_ENABLE 0
`define ACR_MAIN_PURGE 1
`define ACR_MAIN_LAUNCH_LO 2
`define ACR_MAIN_MERGE_LO 6
`define ACR_MODE_FMT_LO 1
`define ACR_MODE_CONT 3
`define ACR_MODE_SIGNED 4
`define ACR_MODE_CAP_LO 5
`define ACR_MODE_IMP 7
`define ACR_REF_TEMP 0
`define ACR_REF_BGAP 1
`define ACR_REF_SEL_LO 4
`define ACR_TRIG_ACT_LO 0
`define ACR_TRIG_SEL_LO 3
`define ACR_TRIG_SWEEP_LO 6
`define ACR_CLK_DIV 4
`endif

// [acr_pkg.sv]
// types shared by the converter control block
package acr_pkg;
   typedef enum logic [2:0] {
      ACR_ACT_NONE = 3'h0,
      ACR_ACT_CH0 = 3'h1,
      ACR_ACT_CH01 = 3'h2,
      ACR_ACT_CH012 = 3'h3,
      ACR_ACT_CH0123 = 3'h4,
      ACR_ACT_SCAN = 3'h5,
      ACR_ACT_SYNC_SCAN = 3'h6,
      ACR_ACT_RSVD = 3'h7
   } acr_action_t;
   typedef enum logic [1:0] {
      ACR_FMT_12R = 2'h0,
      ACR_FMT_RSVD = 2'h1,
      ACR_FMT_8R = 2'h2,
      ACR_FMT_12L = 2'h3
   } acr_format_t;
endpackage

// [acr_clock_gen.sv]
// derived converter clock divider with restart
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_clock_gen #(
   parameter int DIV = `ACR_CLK_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic i_restart,
   input wire logic i_run,
   output logic o_conv_clk,
   output logic o_tick
);
   logic [7:0] cnt_r;
   // restart puts the edge on the very next peripheral clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         o_conv_clk <= 1'b0;
         o_tick <= 1'b0;
      end else if (i_restart || !i_run) begin
         cnt_r <= 8'h00;
         o_conv_clk <= i_run;
         o_tick <= i_run;
      end else begin
         o_tick <= (cnt_r == 8'(DIV - 1));
         cnt_r <= (cnt_r == 8'(DIV - 1)) ? 8'h00 : cnt_r + 8'h01;
         o_conv_clk <= (cnt_r == 8'(DIV - 1)) || (cnt_r < 8'(DIV / 2 - 1));
      end
   end
endmodule

// [acr_control_monitor.sv]
// assertion checker of the converter control block
`timescale 1ns/1ps
module acr_control_monitor #(
   parameter int CHANNELS = 4
) (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic [CHANNELS-1:0] i_dma_req,
   input wire logic [CHANNELS-1:0] i_gain_low,
   input wire logic O_CONV_CLK,
   input wire logic O_CONV_TICK,
   input wire logic O_PURGE,
   input wire logic O_ENABLE,
   input wire logic [CHANNELS-1:0] O_LAUNCH,
   input wire logic [CHANNELS-1:0] O_DMA_REQ,
   input wire logic [CHANNELS-1:0] O_LOW_IMP,
   input wire logic [1:0] O_CURRENT_CAP,
   input wire logic O_SIGNED,
   input wire logic [1:0] O_FORMAT,
   input wire logic [2:0] O_REF_SELECT,
   input wire logic O_BANDGAP,
   input wire logic O_TEMP_SENSOR
);
   logic [7:0] main_r;
   logic [7:0] mode_r;
   logic [7:0] ref_r;
   logic [1:0] live_r;
   // shadow copies of the registers, outputs lag them by one cycle
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         main_r <= 8'h00;
         mode_r <= 8'h00;
         ref_r <= 8'h00;
         live_r <= 2'h0;
      end else begin
         if (i_wr && i_addr == 8'h00) main_r <= i_wdata;
         if (i_wr && i_addr == 8'h01) mode_r <= i_wdata;
         if (i_wr && i_addr == 8'h02) ref_r <= i_wdata;
         if (live_r != 2'h3) live_r <= live_r + 2'h1;
      end
   end
   function automatic logic [3:0] merged(logic [3:0] d, logic [1:0] m);
      logic [3:0] keep;
      keep = 4'hf << (m + 1);
      if (m == 2'h0) return d;
      return (d & keep) | {3'h0, |(d & ~keep)};
   endfunction
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   AST_ONEHOT: assert property ($onehot0(O_LAUNCH)) else $error("launch not one-hot");
   AST_LAUNCH_EN: assert property (|O_LAUNCH |-> O_ENABLE) else $error("launch while off");
   AST_DMA: assert property (live_r[1] |-> O_DMA_REQ == merged($past(i_dma_req), $past(main_r[7:6])))
      else $error("dma merge wrong");
   AST_PURGE: assert property (i_wr && i_addr == 8'h00 && i_wdata[1] |-> ##[2:3] O_PURGE)
      else $error("no purge pulse");
   AST_PURGE_PULSE: assert property (O_PURGE |=> !O_PURGE) else $error("purge too long");
   AST_RESTART: assert property (O_PURGE && O_ENABLE |-> ##[1:2] O_CONV_TICK)
      else $error("clock not restarted");
   AST_STOPPED: assert property ((!O_ENABLE)[*3] |-> !O_CONV_TICK) else $error("tick while off");
   AST_CLK_STOPPED: assert property ((!O_ENABLE)[*3] |-> !O_CONV_CLK) else $error("clock while off");
   AST_TICK_CLK: assert property (O_CONV_TICK |-> O_CONV_CLK) else $error("tick off clock phase");
   AST_MODE: assert property (live_r[1] |-> {O_CURRENT_CAP, O_SIGNED, O_FORMAT} == $past({mode_r[6:4], mode_r[2:1]}))
      else $error("mode fields wrong");
   AST_REF: assert property (live_r[1] |-> {O_REF_SELECT, O_BANDGAP, O_TEMP_SENSOR} == $past({ref_r[6:4], ref_r[1:0]}))
      else $error("reference fields wrong");
   AST_ENABLE: assert property (live_r[1] |-> O_ENABLE == $past(main_r[0])) else $error("enable wrong");
   AST_IMP: assert property (live_r[1] && $stable(i_gain_low) && $stable(mode_r[7])
      |-> O_LOW_IMP == ({4{mode_r[7]}} | i_gain_low)) else $error("impedance wrong");
   cover property (|O_LAUNCH);
   cover property (O_PURGE && O_ENABLE);
   cover property (O_DMA_REQ[0] && main_r[7:6] == 2'h3);
endmodule
bind acr_control acr_control_monitor #(.CHANNELS(CHANNELS)) acr_control_monitor_i (.I_MCLK(I_MCLK),
   .I_SYS_RST(I_SYS_RST), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_dma_req(i_dma_req),
   .i_gain_low(i_gain_low), .O_CONV_CLK(O_CONV_CLK), .O_CONV_TICK(O_CONV_TICK), .O_PURGE(O_PURGE),
   .O_ENABLE(O_ENABLE), .O_LAUNCH(O_LAUNCH), .O_DMA_REQ(O_DMA_REQ), .O_LOW_IMP(O_LOW_IMP),
   .O_CURRENT_CAP(O_CURRENT_CAP), .O_SIGNED(O_SIGNED), .O_FORMAT(O_FORMAT), .O_REF_SELECT(O_REF_SELECT),
   .O_BANDGAP(O_BANDGAP), .O_TEMP_SENSOR(O_TEMP_SENSOR));

// [acr_conv_model.sv]
// converter pipeline, event network and dma source seen by the control block
`timescale 1ns/1ps
module acr_conv_model (
   input wire logic clk,
   input wire logic [7:0] i_fire,
   input wire logic i_stall,
   output logic [7:0] o_event = 8'h00,
   output logic [3:0] o_dma_req = 4'h0,
   output logic [3:0] o_gain_low = 4'h0,
   output logic o_pipe_ready = 1'b1
);
   // gain changes rarely so the impedance check sees settled inputs
   always @(posedge clk) begin
      o_dma_req <= 4'($urandom);
      if ($urandom_range(15) == 0) o_gain_low <= 4'($urandom);
      o_pipe_ready <= !i_stall;
      o_event <= i_fire;
   end
endmodule

// [acr_control_tb.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
module acr_control_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic stall = 1'b0;
   logic [7:0] fire = 8'h00;
   logic [7:0] rdata;
   logic [7:0] ev;
   logic [3:0] launch;
   logic [3:0] dma;
   logic [3:0] gain;
   logic [3:0] seen;
   logic ready;
   logic up;
   int hits;
   int num_errors = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   acr_conv_model acr_conv_model_i (.clk(clk), .i_fire(fire), .i_stall(stall), .o_event(ev),
      .o_dma_req(dma), .o_gain_low(gain), .o_pipe_ready(ready));
   acr_control #(.CLK_DIV(4)) acr_control_i (.I_MCLK(clk), .I_SYS_RST(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .O_RDATA(rdata), .i_event(ev), .i_dma_req(dma),
      .i_gain_low(gain), .i_pipe_ready(ready), .O_CONV_CLK(), .O_CONV_TICK(), .O_PURGE(),
      .O_ENABLE(), .O_LAUNCH(launch), .O_DMA_REQ(), .O_LOW_IMP(), .O_CURRENT_CAP(), .O_SIGNED(),
      .O_FORMAT(), .O_REF_SELECT(), .O_BANDGAP(), .O_TEMP_SENSOR());
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // an idle cycle follows each write so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp, what);
      @(posedge clk);
   endtask
   // collects launches; up drops if a channel is not above all earlier ones
   task automatic watch(input int n);
      repeat (n) begin
         #1;
         if (launch !== 4'h0) begin
            if (launch <= seen) up = 1'b0;
            seen = seen | launch;
            if (launch[3]) hits++;
         end
         @(posedge clk);
      end
   endtask
   function automatic logic [3:0] expect_ev(logic [2:0] act, logic [2:0] sel, logic [1:0] sw);
      logic [3:0] m;
      m = 4'h0;
      for (int k = 0; k < 4; k++) begin
         if (act >= 1 && act <= 4 && k < act && sel + k <= 7) m[k] = 1'b1;
         if ((act == 5 || act == 6) && k <= sw) m[k] = 1'b1;
      end
      return m;
   endfunction
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] d;
      logic [2:0] sel;
      logic [1:0] sw;
      d = 8'($urandom(32'h272b));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 4; a++) rd(8'(a), 8'h00, "reset value");
      rd(8'h07, 8'h00, "unmapped read");
      $display("reset test done");
      repeat (8) begin
         d = 8'($urandom) & 8'hf6; // reserved bit 0 and continuous bit 3 written as zero
         wr(8'h01, d);
         rd(8'h01, d, "mode readback");
         d = {1'b0, 3'($urandom_range(4)), 2'b00, 2'($urandom)};
         wr(8'h02, d);
         rd(8'h02, d, "reference readback");
         d = {2'($urandom), 6'h01};
         wr(8'h00, d);
         rd(8'h00, d, "main readback");
         repeat (6) @(posedge clk);
      end
      $display("config test done");
      wr(8'h01, 8'h00);
      seen = 4'h0;
      up = 1'b1;
      wr(8'h00, 8'h3d);
      watch(40);
      chk({4'h0, seen}, 8'h0f, "launched set");
      chk({7'h0, up}, 8'h01, "launch order");
      rd(8'h00, 8'h01, "starts cleared");
      rd(8'h04, 8'h00, "status idle");
      seen = 4'h0;
      wr(8'h00, 8'h3c);
      watch(30);
      chk({4'h0, seen}, 8'h00, "launch while off");
      $display("launch test done");
      for (int a = 0; a < 8; a++) begin
         sel = 3'($urandom_range(7));
         sw = 2'($urandom);
         wr(8'h03, {sw, sel, 3'(a)});
         wr(8'h00, 8'h01);
         seen = 4'h0;
         fire <= 8'hff;
         watch(3);
         fire <= 8'h00;
         watch(50);
         chk({4'h0, seen}, {4'h0, expect_ev(3'(a), sel, sw)}, "event launch");
      end
      $display("event test done");
      wr(8'h03, 8'h00);
      stall <= 1'b1;
      wr(8'h00, 8'h3d);
      wr(8'h00, 8'h03);
      rd(8'h04, 8'h10, "busy across purge");
      rd(8'h00, 8'h3d, "starts kept across purge");
      seen = 4'h0;
      stall <= 1'b0;
      watch(40);
      chk({4'h0, seen}, 8'h0f, "resume after purge");
      $display("purge test done");
      wr(8'h03, 8'hc0);
      hits = 0;
      wr(8'h01, 8'h08);
      watch(80);
      chk({7'h0, hits >= 2}, 8'h01, "continuous scan");
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h00);
      $display("continuous test done");
      results;
   end
endmodule
